//--- tmrcp_consts.vh
// Constants of the timer counter and period block
`ifndef TMRCP_CONSTS_VH
`define TMRCP_CONSTS_VH

// Register byte offsets
`define TMRCP_OFS_EMU        8'h04
`define TMRCP_OFS_CNT_LO     8'h10
`define TMRCP_OFS_CNT_HI     8'h14
`define TMRCP_OFS_PRD_LO     8'h18
`define TMRCP_OFS_PRD_HI     8'h1C
`define TMRCP_OFS_ENA        8'h20
`define TMRCP_OFS_GLB        8'h24

// Emulation register fields
`define TMRCP_EMU_FREE_BIT   0
`define TMRCP_EMU_SOFT_BIT   1
`define TMRCP_EMU_RATIO_LSB  16
`define TMRCP_EMU_RATIO_MSB  19

// Enable register fields
`define TMRCP_ENA_LO_LSB     0
`define TMRCP_ENA_LO_MSB     1
`define TMRCP_ENA_HI_LSB     2
`define TMRCP_ENA_HI_MSB     3

// Global register fields
`define TMRCP_GLB_REL_LO_BIT 0
`define TMRCP_GLB_REL_HI_BIT 1
`define TMRCP_GLB_MODE_LSB   2
`define TMRCP_GLB_MODE_MSB   3
`define TMRCP_GLB_WATCHDOG_ENABLE_BIT_BIT   4
`define TMRCP_GLB_STOP_LO    5
`define TMRCP_GLB_STOP_HI    6

// Timer mode codes
`define TMRCP_MODE_64        2'h0
`define TMRCP_MODE_UNCHAIN   2'h1
`define TMRCP_MODE_WDOG      2'h2
`define TMRCP_MODE_CHAIN     2'h3

// Enable mode codes
`define TMRCP_ENA_OFF        2'h0
`define TMRCP_ENA_ONCE       2'h1
`define TMRCP_ENA_CONT       2'h2

// Reset values
`define TMRCP_RST_WORD       32'h0000_0000
`define TMRCP_RST_RATIO      4'h1

`endif

//--- tmrcp_top.v
// Counter, period and emulation-suspend logic of a 64-bit timer with APB registers
//
// Chosen here: the register addresses and the APB slave port.
`include "tmrcp_consts.vh"
`default_nettype none

module tmrcp_top #(
	parameter [3:0] CLK_RATIO = `TMRCP_RST_RATIO   // CPU to timer clock ratio code
) (
	input  wire        pclk,             // Timer input clock
	input  wire        presetn,          // Asynchronous reset, active low
	input  wire        psel,             // APB select
	input  wire        penable,          // APB enable
	input  wire        pwrite,           // APB direction, high for write
	input  wire [7:0]  paddr,            // APB byte address
	input  wire [31:0] pwdata,           // APB write data
	output wire [31:0] prdata,           // APB read data
	output wire        pready,           // APB ready
	output wire        pslverr,          // APB error on unmapped address
	input  wire        emu_suspend,      // Emulator access in progress, async
	output wire        lo_match_pulse,   // Low half or 64-bit count hit period
	output wire        hi_match_pulse,   // High half hit period
	output wire        watchdog_mode     // Watchdog mode selected
);

	reg  [31:0] prdata_ff;
	reg         pready_ff;
	reg         pslverr_ff;
	reg  [31:0] cnt_lo_ff;
	reg  [31:0] cnt_hi_ff;
	reg  [31:0] prd_lo_ff;
	reg  [31:0] prd_hi_ff;
	reg  [1:0]  ena_lo_ff;
	reg  [1:0]  ena_hi_ff;
	reg         rel_lo_ff;
	reg         rel_hi_ff;
	reg  [1:0]  tmode_ff;
	reg         watchdog_enable_bit_ff;
	reg         run_free_ff;
	reg         halt_sel_ff;
	reg  [1:0]  soft_stop_ff;
	reg         susp_meta_ff;
	reg         susp_ff;
	reg         lo_match_ff;
	reg         hi_match_ff;
	reg         wdog_ff;

	reg  [31:0] nxt_cnt_lo;
	reg  [31:0] nxt_cnt_hi;
	reg  [1:0]  nxt_ena_lo;
	reg  [1:0]  nxt_ena_hi;
	reg         ev_lo;
	reg         ev_hi;
	reg  [31:0] rd_word;
	reg         rd_hit;

	wire        joined;
	wire        chained;
	wire        wdog_sel;
	wire        stop_lo;
	wire        stop_hi;
	wire        act_lo;
	wire        act_hi;
	wire        match_lo;
	wire        match_hi;
	wire        match64;
	wire [63:0] cnt64;
	wire [63:0] cnt64_inc;
	wire        wr_en;
	wire        setup;

	// Counting enabled for an enable-mode code
	function ena_counts;
		input [1:0] code;
		begin
			ena_counts = (code == `TMRCP_ENA_ONCE) || (code == `TMRCP_ENA_CONT);
		end
	endfunction

	// Address hit helper, unused; read and write decode match paddr in case statements
	function addr_is;
		input [7:0] a;
		input [7:0] ofs;
		begin
			addr_is = (a == ofs);
		end
	endfunction

	assign prdata         = prdata_ff;
	assign pready         = pready_ff;
	assign pslverr        = pslverr_ff;
	assign lo_match_pulse = lo_match_ff;
	assign hi_match_pulse = hi_match_ff;
	assign watchdog_mode  = wdog_ff;

	assign setup = psel & ~penable;
	// Writes land at the access edge only, never on an error
	assign wr_en = psel & penable & pready_ff & pwrite & ~pslverr_ff;

	// Mode 10b alone still counts joined; the watchdog flag needs the enable too
	assign wdog_sel = (tmode_ff == `TMRCP_MODE_WDOG) & watchdog_enable_bit_ff;
	assign joined   = (tmode_ff == `TMRCP_MODE_64) | (tmode_ff == `TMRCP_MODE_WDOG);
	assign chained  = (tmode_ff == `TMRCP_MODE_CHAIN);

	// Suspend response per half
	assign stop_lo = ~run_free_ff & susp_ff & (~halt_sel_ff | soft_stop_ff[0]);
	assign stop_hi = ~run_free_ff & susp_ff & (~halt_sel_ff | soft_stop_ff[1]);

	// Low half drives joined and chained modes, high half only its own unchained counting
	assign act_lo = ena_counts(ena_lo_ff) & rel_lo_ff & ~stop_lo;
	assign act_hi = ena_counts(ena_hi_ff) & rel_hi_ff & ~stop_hi;

	assign cnt64     = {cnt_hi_ff, cnt_lo_ff};
	// One adder, so the low wrap carries into the high half on the same edge
	assign cnt64_inc = cnt64 + 64'h0000_0000_0000_0001;
	assign match64   = (cnt64 == {prd_hi_ff, prd_lo_ff});
	assign match_lo  = (cnt_lo_ff == prd_lo_ff);
	assign match_hi  = (cnt_hi_ff == prd_hi_ff);

	// Counting
	always @*
	begin
		nxt_cnt_lo = cnt_lo_ff;
		nxt_cnt_hi = cnt_hi_ff;
		nxt_ena_lo = ena_lo_ff;
		nxt_ena_hi = ena_hi_ff;
		ev_lo      = 1'b0;
		ev_hi      = 1'b0;
		if (joined)
		begin
			if (act_lo & rel_hi_ff)
			begin
				// Wrap clears both halves on one edge
				if (match64)
				begin
					nxt_cnt_lo = `TMRCP_RST_WORD;
					nxt_cnt_hi = `TMRCP_RST_WORD;
					ev_lo      = 1'b1;
					if (ena_lo_ff == `TMRCP_ENA_ONCE)
						nxt_ena_lo = `TMRCP_ENA_OFF;
				end
				else
				begin
					nxt_cnt_lo = cnt64_inc[31:0];
					nxt_cnt_hi = cnt64_inc[63:32];
				end
			end
		end
		else if (chained)
		begin
			// High half prescales the low half
			if (act_lo & rel_hi_ff)
			begin
				if (match_hi)
				begin
					nxt_cnt_hi = `TMRCP_RST_WORD;
					ev_hi      = 1'b1;
					// Low half steps once per prescaler wrap
					if (match_lo)
					begin
						nxt_cnt_lo = `TMRCP_RST_WORD;
						ev_lo      = 1'b1;
						if (ena_lo_ff == `TMRCP_ENA_ONCE)
							nxt_ena_lo = `TMRCP_ENA_OFF;
					end
					else
						nxt_cnt_lo = cnt_lo_ff + 32'h0000_0001;
				end
				else
					nxt_cnt_hi = cnt_hi_ff + 32'h0000_0001;
			end
		end
		else
		begin
			// Halves run on their own enables and periods
			if (act_lo)
			begin
				if (match_lo)
				begin
					nxt_cnt_lo = `TMRCP_RST_WORD;
					ev_lo      = 1'b1;
					if (ena_lo_ff == `TMRCP_ENA_ONCE)
						nxt_ena_lo = `TMRCP_ENA_OFF;
				end
				else
					nxt_cnt_lo = cnt_lo_ff + 32'h0000_0001;
			end
			if (act_hi)
			begin
				if (match_hi)
				begin
					nxt_cnt_hi = `TMRCP_RST_WORD;
					ev_hi      = 1'b1;
					// One-shot drops to off after its single period
					if (ena_hi_ff == `TMRCP_ENA_ONCE)
						nxt_ena_hi = `TMRCP_ENA_OFF;
				end
				else
					nxt_cnt_hi = cnt_hi_ff + 32'h0000_0001;
			end
		end
	end

	// Read mux
	always @*
	begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (paddr)
		`TMRCP_OFS_EMU:
		begin
			rd_word[`TMRCP_EMU_RATIO_MSB:`TMRCP_EMU_RATIO_LSB] = CLK_RATIO;
			rd_word[`TMRCP_EMU_SOFT_BIT] = halt_sel_ff;
			rd_word[`TMRCP_EMU_FREE_BIT] = run_free_ff;
		end
		`TMRCP_OFS_CNT_LO: rd_word = cnt_lo_ff;
		`TMRCP_OFS_CNT_HI: rd_word = cnt_hi_ff;
		`TMRCP_OFS_PRD_LO: rd_word = prd_lo_ff;
		`TMRCP_OFS_PRD_HI: rd_word = prd_hi_ff;
		`TMRCP_OFS_ENA:
		begin
			rd_word[`TMRCP_ENA_LO_MSB:`TMRCP_ENA_LO_LSB] = ena_lo_ff;
			rd_word[`TMRCP_ENA_HI_MSB:`TMRCP_ENA_HI_LSB] = ena_hi_ff;
		end
		`TMRCP_OFS_GLB:
		begin
			rd_word[`TMRCP_GLB_REL_LO_BIT] = rel_lo_ff;
			rd_word[`TMRCP_GLB_REL_HI_BIT] = rel_hi_ff;
			rd_word[`TMRCP_GLB_MODE_MSB:`TMRCP_GLB_MODE_LSB] = tmode_ff;
			rd_word[`TMRCP_GLB_WATCHDOG_ENABLE_BIT_BIT] = watchdog_enable_bit_ff;
			rd_word[`TMRCP_GLB_STOP_LO] = stop_lo;
			rd_word[`TMRCP_GLB_STOP_HI] = stop_hi;
		end
		// Unmapped offsets answer with an error
		default: rd_hit = 1'b0;
		endcase
	end

	// Suspend synchroniser
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			susp_meta_ff <= 1'b0;
			susp_ff      <= 1'b0;
		end
		else
		begin
			// First stage feeds only the second
			susp_meta_ff <= emu_suspend;
			susp_ff      <= susp_meta_ff;
		end
	end

	// APB slave, one wait-free access phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end
		else
		begin
			pready_ff  <= setup;
			pslverr_ff <= setup & ~rd_hit;
			// Read data taken at setup so it stands through the access cycle
			if (setup & ~pwrite)
				prdata_ff <= rd_word;
			else if (setup)
				prdata_ff <= 32'h0000_0000;
		end
	end

	// Configuration and counter state
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_lo_ff    <= `TMRCP_RST_WORD;
			cnt_hi_ff    <= `TMRCP_RST_WORD;
			prd_lo_ff    <= `TMRCP_RST_WORD;
			prd_hi_ff    <= `TMRCP_RST_WORD;
			ena_lo_ff    <= `TMRCP_ENA_OFF;
			ena_hi_ff    <= `TMRCP_ENA_OFF;
			// Counters stay held after reset until software releases them
			rel_lo_ff    <= 1'b0;
			rel_hi_ff    <= 1'b0;
			tmode_ff     <= `TMRCP_MODE_64;
			watchdog_enable_bit_ff      <= 1'b0;
			run_free_ff  <= 1'b0;
			halt_sel_ff  <= 1'b0;
			soft_stop_ff <= 2'h0;
			lo_match_ff  <= 1'b0;
			hi_match_ff  <= 1'b0;
			wdog_ff      <= 1'b0;
		end
		else
		begin
			cnt_lo_ff   <= nxt_cnt_lo;
			cnt_hi_ff   <= nxt_cnt_hi;
			ena_lo_ff   <= nxt_ena_lo;
			ena_hi_ff   <= nxt_ena_hi;
			lo_match_ff <= ev_lo;
			hi_match_ff <= ev_hi;
			wdog_ff     <= wdog_sel;
			// Latch stop once the period is reached while suspended
			if (!susp_ff)
				soft_stop_ff <= 2'h0;
			else if (halt_sel_ff)
			begin
				if (ev_lo)
					soft_stop_ff[0] <= 1'b1;
				if (ev_hi | (joined & ev_lo))
					soft_stop_ff[1] <= 1'b1;
			end
			// Bus write placed last so it wins over counting
			if (wr_en)
			begin
				case (paddr)
				`TMRCP_OFS_EMU:
				begin
					run_free_ff <= pwdata[`TMRCP_EMU_FREE_BIT];
					halt_sel_ff <= pwdata[`TMRCP_EMU_SOFT_BIT];
				end
				`TMRCP_OFS_CNT_LO: cnt_lo_ff <= pwdata;
				`TMRCP_OFS_CNT_HI: cnt_hi_ff <= pwdata;
				`TMRCP_OFS_PRD_LO: prd_lo_ff <= pwdata;
				`TMRCP_OFS_PRD_HI: prd_hi_ff <= pwdata;
				`TMRCP_OFS_ENA:
				begin
					ena_lo_ff <= pwdata[`TMRCP_ENA_LO_MSB:`TMRCP_ENA_LO_LSB];
					ena_hi_ff <= pwdata[`TMRCP_ENA_HI_MSB:`TMRCP_ENA_HI_LSB];
				end
				`TMRCP_OFS_GLB:
				begin
					// Release bits only gate counting, never clear counters
					rel_lo_ff <= pwdata[`TMRCP_GLB_REL_LO_BIT];
					rel_hi_ff <= pwdata[`TMRCP_GLB_REL_HI_BIT];
					tmode_ff  <= pwdata[`TMRCP_GLB_MODE_MSB:`TMRCP_GLB_MODE_LSB];
					watchdog_enable_bit_ff   <= pwdata[`TMRCP_GLB_WATCHDOG_ENABLE_BIT_BIT];
				end
				default:
				begin
				end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

//--- tmrcp_sva.sv
// Assertion checker for the timer counter and period block
`include "tmrcp_consts.vh"
`default_nettype none
module tmrcp_sva #(
	parameter logic [3:0] CLK_RATIO = 4'h1   // Ratio code
) (
	input wire logic        pclk,           // Clock
	input wire logic        presetn,        // Reset, active low
	input wire logic        psel,           // Select
	input wire logic        penable,        // Enable
	input wire logic        pwrite,         // Direction
	input wire logic [7:0]  paddr,          // Address
	input wire logic [31:0] pwdata,         // Write data
	input wire logic [31:0] prdata,         // Read data
	input wire logic        pready,         // Ready
	input wire logic        pslverr,        // Error
	input wire logic        emu_suspend,    // Suspend
	input wire logic        lo_match_pulse, // Low match
	input wire logic        hi_match_pulse, // High match
	input wire logic        watchdog_mode   // Watchdog level
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic emu_rd;
	logic glb_wr;
	assign emu_rd = psel && penable && pready && !pwrite && paddr == `TMRCP_OFS_EMU;
	assign glb_wr = psel && penable && pready && pwrite && paddr == `TMRCP_OFS_GLB;
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		pready ##1 !pready;
	endsequence
	apb_answer_a: assert property (setup_s |=> access_s)
		else $error("no ready after setup");
	ready_access_a: assert property (pready |-> $past(psel && !penable))
		else $error("ready outside access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	emu_reserved_a: assert property (emu_rd |-> prdata[31:20] == 0 && prdata[15:2] == 0)
		else $error("reserved bits not zero");
	ratio_field_a: assert property (emu_rd |-> prdata[19:16] == CLK_RATIO)
		else $error("ratio field wrong");
	ratio_code_a: assert property (emu_rd |-> prdata[19:16] inside {1, 2, 4, 6, 8})
		else $error("ratio code reserved");
	wdog_select_a: assert property (glb_wr |-> ##2
		watchdog_mode == $past(pwdata[3:2] == `TMRCP_MODE_WDOG && pwdata[4], 2))
		else $error("watchdog mode wrong");
	wdog_hold_a: assert property ($changed(watchdog_mode) |-> $past(glb_wr, 2))
		else $error("watchdog mode changed alone");
endmodule

bind tmrcp_top tmrcp_sva #(.CLK_RATIO(CLK_RATIO)) u_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .emu_suspend(emu_suspend),
	.lo_match_pulse(lo_match_pulse), .hi_match_pulse(hi_match_pulse),
	.watchdog_mode(watchdog_mode));
`default_nettype wire

//--- tb_tmrcp_top.sv
// Self-checking testbench of the timer counter and period block
`include "tmrcp_consts.vh"
`default_nettype none
module tb_tmrcp_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {string nm; logic [32:0] v;} tmrcp_exp_t;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, emu_suspend = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, rnd = 32'h9005_7B77;
	wire [31:0]  prdata;
	wire         pready, pslverr, lo_p, hi_p, wdog;
	int          failures = 0, checks_done = 0, pulses = 0, hi_pulses = 0;
	tmrcp_exp_t  q[$];
	tmrcp_top #(.CLK_RATIO(4'h6)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .emu_suspend(emu_suspend),
		.lo_match_pulse(lo_p), .hi_match_pulse(hi_p), .watchdog_mode(wdog));
	initial forever #50 pclk = ~pclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			failures++;
			print_verdict();
		end
		else
		begin
			psel <= 0;
			penable <= 0;
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e, input string nm);
		q.push_back('{nm, e});
		xfer(0, a, 32'h0);
	endtask
	task automatic run(input logic [31:0] glb, input int k);
		xfer(1, `TMRCP_OFS_GLB, glb);
		xfer(1, `TMRCP_OFS_ENA, 32'h2);
		repeat (k) @(posedge pclk);
		xfer(1, `TMRCP_OFS_ENA, 32'h0);
	endtask
	always @(posedge pclk)
	begin
		tmrcp_exp_t e;
		if (psel && penable && pready && !pwrite && q.size() > 0)
		begin
			e = q.pop_front();
			check(e.nm, {pslverr, prdata}, e.v);
		end
		if (lo_p === 1'b1)
			pulses++;
		if (hi_p === 1'b1)
			hi_pulses++;
	end
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		rd(`TMRCP_OFS_EMU, 33'h0_0006_0000, "emu");
		xfer(1, `TMRCP_OFS_EMU, 32'hFFFF_FFFC);
		rd(`TMRCP_OFS_EMU, 33'h0_0006_0000, "emu_rsv");
		rd(8'h08, {1'b1, 32'h0}, "unmapped");
		for (int i = 0; i < 4; i++)
		begin
			rnd = lfsr(rnd);
			rd(`TMRCP_OFS_CNT_LO + 8'(i * 4), 33'h0, "word_rst");
			xfer(1, `TMRCP_OFS_CNT_LO + 8'(i * 4), rnd);
			rd(`TMRCP_OFS_CNT_LO + 8'(i * 4), {1'b0, rnd}, "word");
		end
		$display("test registers done");
		xfer(1, `TMRCP_OFS_CNT_LO, 32'hFFFF_FFF0);
		xfer(1, `TMRCP_OFS_CNT_HI, 32'h0);
		xfer(1, `TMRCP_OFS_PRD_LO, 32'h0);
		xfer(1, `TMRCP_OFS_PRD_HI, 32'h2);
		run(32'h0, 5);
		rd(`TMRCP_OFS_CNT_LO, 33'h0_FFFF_FFF0, "held");
		xfer(1, `TMRCP_OFS_GLB, 32'h3);
		repeat (5) @(posedge pclk);
		rd(`TMRCP_OFS_CNT_LO, 33'h0_FFFF_FFF0, "idle");
		run(32'h3, 29);
		rd(`TMRCP_OFS_CNT_LO, 33'h10, "join_lo");
		rd(`TMRCP_OFS_CNT_HI, 33'h1, "join_hi");
		$display("test joined done");
		xfer(1, `TMRCP_OFS_CNT_LO, 32'h0);
		xfer(1, `TMRCP_OFS_CNT_HI, 32'h0);
		xfer(1, `TMRCP_OFS_PRD_LO, 32'h2);
		pulses = 0;
		run(32'h7, 7);
		rd(`TMRCP_OFS_CNT_LO, 33'h1, "wrap");
		rd(`TMRCP_OFS_CNT_HI, 33'h0, "alone");
		check("pulses", 33'(pulses), 33'h3);
		xfer(1, `TMRCP_OFS_CNT_LO, 32'h0);
		xfer(1, `TMRCP_OFS_PRD_HI, 32'h1);
		xfer(1, `TMRCP_OFS_PRD_LO, 32'h64);
		hi_pulses = 0;
		run(32'hF, 8);
		rd(`TMRCP_OFS_CNT_HI, 33'h1, "prescale");
		check("hi_pulses", 33'(hi_pulses), 33'h5);
		rd(`TMRCP_OFS_CNT_LO, 33'h5, "chain");
		$display("test dual done");
		xfer(1, `TMRCP_OFS_CNT_LO, 32'h0);
		xfer(1, `TMRCP_OFS_PRD_LO, 32'h5);
		emu_suspend <= 1;
		run(32'h7, 5);
		rd(`TMRCP_OFS_CNT_LO, 33'h0, "stop");
		xfer(1, `TMRCP_OFS_EMU, 32'h1);
		run(32'h7, 5);
		rd(`TMRCP_OFS_CNT_LO, 33'h2, "free");
		xfer(1, `TMRCP_OFS_EMU, 32'h2);
		xfer(1, `TMRCP_OFS_CNT_LO, 32'h0);
		pulses = 0;
		run(32'h7, 20);
		rd(`TMRCP_OFS_CNT_LO, 33'h0, "soft");
		check("soft_pulses", 33'(pulses), 33'h1);
		emu_suspend <= 0;
		$display("test suspend done");
		xfer(1, `TMRCP_OFS_GLB, 32'h1B);
		repeat (3) @(posedge pclk);
		check("wdog", {32'h0, wdog}, 33'h1);
		rnd = lfsr(rnd);
		xfer(1, `TMRCP_OFS_CNT_LO, rnd);
		rd(`TMRCP_OFS_CNT_LO, {1'b0, rnd}, "pre_rst");
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		rd(`TMRCP_OFS_CNT_LO, 33'h0, "hw_rst_lo");
		rd(`TMRCP_OFS_CNT_HI, 33'h0, "hw_rst_hi");
		check("wdog_rst", {32'h0, wdog}, 33'h0);
		$display("test reset done");
		repeat (2) @(posedge pclk);
		print_verdict();
	end
endmodule
`default_nettype wire
